// ---- trigger_delay_down_counter.sv ----
// Trigger-delay down counter: prescaler, four-stage down counter, enable
// logic and the sampling-mode converter register.
// Assumes all inputs synchronous to ref_clk and timebase pulses one cycle long.
//
// Function
// R1 - Either timebase gives 25 pulses per division
// R2 - Slow below 125 kHz, fast above, merged
// R3 - Divide-by-five prescaler clocks the down counter
// R4 - First write at 8086 loads lower stages
// R5 - Second write at 8085 loads upper stages
// R6 - Count enable needs armed state and trigger rise
// R7 - Next timebase pulse syncs and starts prescaler
// R8 - Zero count clears enable, stops prescaler
// R9 - Load-block low during reload keeps blocked
// R10 - After load, next trigger re-arms counting
// R11 - Blocked after finishing drives delayed trigger high
// R12 - Sampling mode: converter written at 8086
// R13 - Converter register holds until next write
// R14 - Software codes two steps per division
// R15 - Zero delay still gives ten divisions
// R16 - Counter path only in direct and CCD
// R17 - Four 4-bit stages, 8 bits per write
// R18 - Selected timebase follows setting, other idle
`timescale 1ns/1ns
module trigger_delay_down_counter
(
  input wire logic ref_clk,
  input wire logic rst_n,
  delay_bus_if.dev bus,
  input wire logic fast_timebase_pulses,
  input wire logic slow_timebase_pulses,
  input wire logic trigger_stretch_pulse,
  output logic delay_count_enable_n,
  output logic load_block_pulse_n,
  output logic delayed_trigger,
  output logic [7:0] delay_converter_output
);
  import delay_pkg::*;
  // ----------------------------------------
  // Bus write decode
  // ----------------------------------------
  logic wr_n_q;
  logic wr_take;
  logic sampling;
  logic wr_lower;
  logic wr_upper;
  logic wr_conv;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_n_q <= 1'b1;
    end
    else
    begin
      wr_n_q <= bus.wr_n;
    end
  end
  // One write per falling strobe edge, however long the strobe stands
  assign wr_take = wr_n_q && !bus.wr_n && !bus.io_sel_n;
  assign sampling = (bus.mode == MODE_SAMPLING);
  always_comb
  begin
    wr_lower = 1'b0;
    wr_upper = 1'b0;
    wr_conv = 1'b0;
    if (wr_take && bus.addr == ADDR_CONVERTER && sampling)
    begin
      wr_conv = 1'b1; // R12
    end
    else if (wr_take && bus.addr == ADDR_COUNT_LOWER)
    begin
      wr_lower = 1'b1; // R4
    end
    else if (wr_take && bus.addr == ADDR_COUNT_UPPER)
    begin
      wr_upper = 1'b1; // R5
    end
  end
  // ----------------------------------------
  // Converter register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      delay_converter_output <= CONVERTER_RESET;
    end
    else if (wr_conv)
    begin
      delay_converter_output <= bus.data; // R13
    end
  end
  // ----------------------------------------
  // Reload sequence
  // ----------------------------------------
  logic loading_q;
  // Low from the lower-half write until the upper-half write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loading_q <= 1'b0;
    end
    else if (wr_lower)
    begin
      loading_q <= 1'b1; // R9
    end
    else if (wr_upper)
    begin
      loading_q <= 1'b0; // R10
    end
  end
  assign load_block_pulse_n = !loading_q;
  // ----------------------------------------
  // Timebase selection
  // ----------------------------------------
  logic tb_pulse;
  // Unselected source is gated off entirely
  assign tb_pulse = bus.slow_sel ? slow_timebase_pulses : fast_timebase_pulses; // R2 R18
  // ----------------------------------------
  // Enable flip-flop and trigger edge
  // ----------------------------------------
  logic trig_q;
  logic trig_rise;
  logic done_q;
  logic arm_ok;
  logic count_en_q;
  logic finish;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_q <= 1'b0;
    end
    else
    begin
      trig_q <= trigger_stretch_pulse;
    end
  end
  assign trig_rise = trigger_stretch_pulse && !trig_q;
  // Reset input of the enable flip-flop: high only when loaded and not finished
  assign arm_ok = load_block_pulse_n && !done_q && !wr_lower;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_en_q <= 1'b0;
    end
    else if (!arm_ok || finish)
    begin
      count_en_q <= 1'b0; // R8 R9
    end
    else if (trig_rise && !sampling)
    begin
      count_en_q <= 1'b1; // R6 R10 R16
    end
  end
  assign delay_count_enable_n = !count_en_q;
  // ----------------------------------------
  // Synchronising flip-flop and prescaler
  // ----------------------------------------
  logic sync_q;
  logic [2:0] pre_q;
  logic tick;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= 1'b0;
    end
    else if (!count_en_q || finish)
    begin
      sync_q <= 1'b0; // R8
    end
    else if (tb_pulse)
    begin
      sync_q <= 1'b1; // R7
    end
  end
  // Five timebase pulses per tick: 25 per division gives 5 ticks per division
  assign tick = sync_q && tb_pulse && (pre_q == PRESCALE_DIV - 3'h1); // R1 R3
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q <= 3'h0;
    end
    else if (!sync_q || tick)
    begin
      pre_q <= 3'h0; // R3
    end
    else if (tb_pulse)
    begin
      pre_q <= pre_q + 3'h1;
    end
  end
  // ----------------------------------------
  // Down counter and fixed offset
  // ----------------------------------------
  logic [15:0] count_q;
  logic [15:0] load_q;
  logic [7:0] offset_q;
  // Ends on the tick that empties offset and count together: load N gives 50 + N ticks
  assign finish = tick && (offset_q == 8'h00 ? count_q == 16'h0001 :
    (offset_q == 8'h01 && count_q == 16'h0000)); // R15
  // Stages are reloaded from the last written value at every arming
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_q <= COUNT_RESET;
    end
    else if (wr_lower)
    begin
      load_q[7:0] <= bus.data; // R4 R17
    end
    else if (wr_upper)
    begin
      load_q[15:8] <= bus.data; // R5 R17
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= COUNT_RESET;
      offset_q <= ZERO_DELAY_TICKS;
    end
    else if (!count_en_q)
    begin
      count_q <= load_q;
      offset_q <= ZERO_DELAY_TICKS;
    end
    else if (tick && offset_q != 8'h00)
    begin
      offset_q <= offset_q - 8'h01; // R15
    end
    else if (tick && count_q != 16'h0000)
    begin
      count_q <= count_q - 16'h0001; // R3
    end
  end
  // ----------------------------------------
  // Finished state and delayed trigger
  // ----------------------------------------
  // Out of reset the counter is unloaded, so it stands blocked
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_q <= 1'b1;
    end
    else if (finish)
    begin
      done_q <= 1'b1; // R8
    end
    else if (wr_upper)
    begin
      done_q <= 1'b0; // R10
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      delayed_trigger <= 1'b1;
    end
    else
    begin
      delayed_trigger <= done_q || finish; // R11
    end
  end
endmodule // trigger_delay_down_counter

// ---- delay_pkg.sv ----
// Shared constants for the trigger-delay down counter and its bus master.
// Assumes one 10 MHz clock; timebase pulses arrive as one-cycle strobes.
package delay_pkg;
  // ----------------------------------------
  // Bus addresses
  // ----------------------------------------
  localparam logic [15:0] ADDR_COUNT_UPPER = 16'h8085;
  localparam logic [15:0] ADDR_COUNT_LOWER = 16'h8086;
  localparam logic [15:0] ADDR_CONVERTER = 16'h8086;
  // ----------------------------------------
  // Counting figures
  // ----------------------------------------
  localparam int PULSES_PER_DIV = 25;
  localparam logic [2:0] PRESCALE_DIV = 3'h5;
  localparam int ZERO_DELAY_DIVS = 10;
  localparam logic [7:0] ZERO_DELAY_TICKS = 8'(ZERO_DELAY_DIVS * PULSES_PER_DIV / int'(PRESCALE_DIV));
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] CONVERTER_RESET = 8'h00;
  localparam int SAMPLE_RANGE_DIVS = 100;
  localparam int SAMPLE_CODES_PER_DIV = 2;
  localparam logic [6:0] SAMPLE_MAX_DIVS = 7'(SAMPLE_RANGE_DIVS);
  // ----------------------------------------
  // Bus write timing, in clock cycles
  // ----------------------------------------
  localparam logic [1:0] WR_STROBE_CYCLES = 2'h2;
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0,
    MODE_CCD = 2'h1,
    MODE_SAMPLING = 2'h3
  } capture_mode_t;
endpackage

// ---- delay_bus_if.sv ----
// Processor system bus between the bus master and the trigger-delay block.
// Write-only bus; the master alone drives every signal.
`timescale 1ns/1ns
interface delay_bus_if;
  import delay_pkg::*;
  logic [15:0] addr;
  logic [7:0] data;
  logic io_sel_n;
  logic wr_n;
  capture_mode_t mode;
  logic slow_sel;
  modport host (output addr, output data, output io_sel_n, output wr_n, output mode,
    output slow_sel);
  modport dev (input addr, input data, input io_sel_n, input wr_n, input mode,
    input slow_sel);
endinterface

// ---- delay_bus_master.sv ----
// Processor-side bus master: issues count loads and converter writes.
// Assumes user requests are held until accepted by req_ready.
`timescale 1ns/1ns
module delay_bus_master
(
  input wire logic ref_clk,
  input wire logic rst_n,
  delay_bus_if.host bus,
  input wire delay_pkg::capture_mode_t mode,
  input wire logic slow_sel,
  input wire logic req_valid,
  input wire logic req_is_count,
  input wire logic [15:0] req_count,
  input wire logic [6:0] req_divs,
  output logic req_ready
);
  import delay_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b11,
    ST_GAP = 2'b10
  } host_state_t;

  host_state_t state_q;
  logic [1:0] cnt_q;
  logic second_q;
  logic [7:0] upper_q;

  // Two codes per division; out-of-range requests clamp at full scale
  function automatic logic [7:0] div_code(input logic [6:0] divs);
    logic [6:0] d;
    d = (divs > SAMPLE_MAX_DIVS) ? SAMPLE_MAX_DIVS : divs;
    return 8'(d * SAMPLE_CODES_PER_DIV); // R14
  endfunction

  assign req_ready = (state_q == ST_IDLE);
  assign bus.mode = mode;
  assign bus.slow_sel = slow_sel;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      second_q <= 1'b0;
      upper_q <= 8'h00;
      bus.addr <= 16'h0000;
      bus.data <= 8'h00;
      bus.io_sel_n <= 1'b1;
      bus.wr_n <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            state_q <= ST_SETUP;
            bus.io_sel_n <= 1'b0;
            if (req_is_count)
            begin
              bus.addr <= ADDR_COUNT_LOWER; // R4
              bus.data <= req_count[7:0];
              upper_q <= req_count[15:8];
              second_q <= 1'b1;
            end
            else
            begin
              bus.addr <= ADDR_CONVERTER; // R12
              bus.data <= div_code(req_divs);
              second_q <= 1'b0;
            end
          end
        end
        ST_SETUP:
        begin
          state_q <= ST_STROBE;
          bus.wr_n <= 1'b0;
          cnt_q <= WR_STROBE_CYCLES - 2'h1;
        end
        ST_STROBE:
        begin
          if (cnt_q == 2'h0)
          begin
            state_q <= ST_GAP;
            bus.wr_n <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        ST_GAP:
        begin
          if (second_q)
          begin
            state_q <= ST_SETUP;
            second_q <= 1'b0;
            bus.addr <= ADDR_COUNT_UPPER; // R5
            bus.data <= upper_q;
          end
          else
          begin
            state_q <= ST_IDLE;
            bus.io_sel_n <= 1'b1;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // delay_bus_master

// ---- trigger_delay_chk.sv ----
// Checker for the trigger-delay bus and counter outputs.
// Assumes bus signals and device ports are wired in by name.
`timescale 1ns/1ns
module trigger_delay_chk
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] data,
  input wire logic io_sel_n,
  input wire logic wr_n,
  input wire delay_pkg::capture_mode_t mode,
  input wire logic trigger_stretch_pulse,
  input wire logic delay_count_enable_n,
  input wire logic load_block_pulse_n,
  input wire logic delayed_trigger,
  input wire logic [7:0] delay_converter_output
);
  import delay_pkg::*;
  logic wr_prev_q;
  logic take;
  logic conv_take;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_prev_q <= 1'b1;
    else
      wr_prev_q <= wr_n;
  end
  // Long strobes are taken once, on the first low edge
  assign take = !io_sel_n && !wr_n && wr_prev_q;
  assign conv_take = take && addr == ADDR_CONVERTER && mode == MODE_SAMPLING;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_CONV_LOAD:
    assert property (conv_take |=> delay_converter_output == $past(data))
    else $error("converter not loaded");
  AST_CONV_HOLD:
    assert property (!conv_take |=> $stable(delay_converter_output))
    else $error("converter changed");
  AST_LOWER_BLOCKS:
    assert property (take && addr == ADDR_COUNT_LOWER && mode != MODE_SAMPLING
      |=> !load_block_pulse_n) else $error("lower write did not block");
  AST_UPPER_AFTER_LOWER:
    assert property (take && addr == ADDR_COUNT_UPPER |-> !load_block_pulse_n)
    else $error("upper write without lower");
  AST_UPPER_RELEASE:
    assert property (take && addr == ADDR_COUNT_UPPER |-> ##[1:2] load_block_pulse_n)
    else $error("load block not released");
  AST_BLOCK_HALTS:
    assert property (!load_block_pulse_n |-> delay_count_enable_n)
    else $error("counting during load");
  AST_COUNT_NOT_DONE:
    assert property (!delay_count_enable_n |-> !delayed_trigger)
    else $error("delayed trigger while counting");
  AST_FINISH:
    assert property ($rose(delay_count_enable_n) && load_block_pulse_n |-> delayed_trigger)
    else $error("stop without delayed trigger");
  AST_ARM:
    assert property ($fell(delay_count_enable_n)
      |-> $past(trigger_stretch_pulse) && !$past(trigger_stretch_pulse, 2))
    else $error("enable without trigger rise");
  AST_SAMPLING_IDLE:
    assert property (mode == MODE_SAMPLING && delay_count_enable_n |=> delay_count_enable_n)
    else $error("counting in sampling mode");
  AST_STROBE:
    assert property ($fell(wr_n) |-> (!io_sel_n && !wr_n) [*2] ##1 wr_n)
    else $error("bad write strobe");
  cover property (conv_take);
  cover property ($rose(delayed_trigger));
  cover property ($fell(delay_count_enable_n));
endmodule // trigger_delay_chk

// ---- trigger_delay_down_counter_tb.sv ----
// Bench: bus master and trigger-delay block joined by the bus interface.
// Assumes 10 MHz ref_clk; inputs change 5 ns after the rising edge.
`timescale 1ns/1ns
module trigger_delay_down_counter_tb;
  import delay_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fast_timebase_pulses = 1'b0;
  logic slow_timebase_pulses = 1'b0;
  logic trigger_stretch_pulse = 1'b0;
  logic delay_count_enable_n;
  logic load_block_pulse_n;
  logic delayed_trigger;
  logic [7:0] delay_converter_output;
  capture_mode_t mode_s = MODE_DIRECT;
  logic slow_s = 1'b0;
  logic req_valid = 1'b0;
  logic req_is_count = 1'b0;
  logic [15:0] req_count = 16'h0000;
  logic [6:0] req_divs = 7'h00;
  logic req_ready;
  logic lb_low = 1'b0;
  logic wr_prev = 1'b1;
  logic [15:0] seen_addr[$];
  int mismatches = 0;
  int compares = 0;
  always #50 ref_clk = ~ref_clk;
  delay_bus_if delay_bus_if_i();
  delay_bus_master delay_bus_master_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(delay_bus_if_i.host), .mode(mode_s), .slow_sel(slow_s), .req_valid(req_valid),
    .req_is_count(req_is_count), .req_count(req_count), .req_divs(req_divs),
    .req_ready(req_ready));
  trigger_delay_down_counter trigger_delay_down_counter_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(delay_bus_if_i.dev), .fast_timebase_pulses(fast_timebase_pulses),
    .slow_timebase_pulses(slow_timebase_pulses), .trigger_stretch_pulse(trigger_stretch_pulse),
    .delay_count_enable_n(delay_count_enable_n), .load_block_pulse_n(load_block_pulse_n),
    .delayed_trigger(delayed_trigger), .delay_converter_output(delay_converter_output));
  trigger_delay_chk trigger_delay_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(delay_bus_if_i.addr), .data(delay_bus_if_i.data), .io_sel_n(delay_bus_if_i.io_sel_n),
    .wr_n(delay_bus_if_i.wr_n), .mode(delay_bus_if_i.mode),
    .trigger_stretch_pulse(trigger_stretch_pulse), .delay_count_enable_n(delay_count_enable_n),
    .load_block_pulse_n(load_block_pulse_n), .delayed_trigger(delayed_trigger),
    .delay_converter_output(delay_converter_output));
  // ----------------------------------------
  // Wire monitor and shared tasks
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (delay_bus_if_i.wr_n === 1'b0 && wr_prev === 1'b1)
      seen_addr.push_back(delay_bus_if_i.addr);
    wr_prev <= delay_bus_if_i.wr_n;
    if (load_block_pulse_n === 1'b0)
      lb_low <= 1'b1;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic request(input logic is_count, input logic [15:0] cnt, input logic [6:0] divs);
    int i;
    i = 0;
    @(posedge ref_clk);
    #5;
    seen_addr.delete();
    lb_low = 1'b0;
    req_valid = 1'b1;
    req_is_count = is_count;
    req_count = cnt;
    req_divs = divs;
    @(posedge ref_clk);
    #5;
    req_valid = 1'b0;
    @(posedge ref_clk);
    #5;
    while (req_ready !== 1'b1 && i < 40)
    begin
      @(posedge ref_clk);
      #5;
      i++;
    end
    repeat (3) @(posedge ref_clk);
    #5;
    check("ready", {15'h0, req_ready}, 16'h1);
  endtask
  task automatic trig();
    @(posedge ref_clk);
    #5;
    trigger_stretch_pulse = 1'b1;
    repeat (2) @(posedge ref_clk);
    #5;
    trigger_stretch_pulse = 1'b0;
  endtask
  // Unselected source pulses in between; a wrong merge would count double
  task automatic run_delay(input logic slow, input int n);
    int cnt;
    int exp;
    cnt = 0;
    exp = 1 + int'(PRESCALE_DIV) * (int'(ZERO_DELAY_TICKS) + n);
    trig();
    check("armed", {15'h0, delay_count_enable_n}, 16'h0);
    while (delayed_trigger !== 1'b1 && cnt < 2000)
    begin
      slow_timebase_pulses = slow;
      fast_timebase_pulses = !slow;
      @(posedge ref_clk);
      #5;
      slow_timebase_pulses = !slow;
      fast_timebase_pulses = slow;
      cnt++;
      @(posedge ref_clk);
      #5;
    end
    slow_timebase_pulses = 1'b0;
    fast_timebase_pulses = 1'b0;
    check("pulse count", 16'(cnt), 16'(exp));
    check("stopped", {15'h0, delay_count_enable_n}, 16'h1);
    trig();
    check("no rearm", {15'h0, delay_count_enable_n}, 16'h1);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    stop_test();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #5;
    rst_n = 1'b1;
    check("reset trigger", {15'h0, delayed_trigger}, 16'h1);
    check("reset block", {15'h0, load_block_pulse_n}, 16'h1);
    request(1'b1, 16'h0003, 7'h00);
    check("first addr", seen_addr[0], ADDR_COUNT_LOWER);
    check("second addr", seen_addr[1], ADDR_COUNT_UPPER);
    check("blocked in load", {15'h0, lb_low}, 16'h1);
    check("released", {15'h0, load_block_pulse_n}, 16'h1);
    run_delay(1'b0, 3);
    mode_s = MODE_CCD;
    slow_s = 1'b1;
    request(1'b1, 16'h0000, 7'h00);
    run_delay(1'b1, 0);
    request(1'b1, 16'h0005, 7'h00);
    mode_s = MODE_SAMPLING;
    trig();
    check("sampling idle", {15'h0, delay_count_enable_n}, 16'h1);
    request(1'b0, 16'h0000, 7'h07);
    check("conv addr", seen_addr[0], ADDR_CONVERTER);
    check("conv no block", {15'h0, lb_low}, 16'h0);
    check("conv 7 div", {8'h0, delay_converter_output}, 16'h000e);
    request(1'b0, 16'h0000, 7'h7f);
    check("conv clamp", {8'h0, delay_converter_output}, 16'h00c8);
    mode_s = MODE_DIRECT;
    request(1'b1, 16'h0001, 7'h00);
    check("conv hold", {8'h0, delay_converter_output}, 16'h00c8);
    stop_test();
  end
endmodule // trigger_delay_down_counter_tb
